//--- inc/scc_cfg.svh
`ifndef SCC_CFG_SVH
`define SCC_CFG_SVH

// register indices; byte address is four times the index
`define SCC_IDX_S0_CTRL 7'h51
`define SCC_IDX_S0_MODE 7'h52
`define SCC_IDX_S0_BAUD 7'h53
`define SCC_IDX_S1_BUF 7'h54
`define SCC_IDX_S1_CTRL 7'h55
`define SCC_IDX_S1_MODE 7'h56
`define SCC_IDX_S1_BAUD 7'h57
`define SCC_IDX_ODE 7'h58
`define SCC_IDX_INT_STAT 7'h59
`define SCC_IDX_INT_MASK 7'h5A

// control register bits
`define SCC_B_RX9 7
`define SCC_B_EVEN 6
`define SCC_B_PEN 5
`define SCC_B_OVR 4
`define SCC_B_PER 3
`define SCC_B_FER 2
`define SCC_B_EDGE 1
`define SCC_B_PINSRC 0
// mode register bits and fields
`define SCC_B_TX9 7
`define SCC_B_CTS 6
`define SCC_B_RXEN 5
`define SCC_B_WAKE 4
`define SCC_F_FRAME 3:2
`define SCC_F_CLKSRC 1:0
// baud register fields
`define SCC_F_PRESC 5:4
`define SCC_F_DIV 3:0

// interrupt status layout, four bits per channel
`define SCC_IRQ_PER_CH 4
`define SCC_IRQ_RX 0
`define SCC_IRQ_OVR 1
`define SCC_IRQ_PER 2
`define SCC_IRQ_FER 3

// reset value of every register
`define SCC_RST_REG 8'h00

// prescaler tap masks for fc/4, fc/16, fc/64, fc/256
`define SCC_PRE_MASK_4 8'h03
`define SCC_PRE_MASK_16 8'h0F
`define SCC_PRE_MASK_64 8'h3F
`define SCC_PRE_MASK_256 8'hFF

`endif

//--- inc/scc_pkg.sv
package scc_pkg;

    // frame type codes in field order
    typedef enum logic [1:0] {
        SCC_FR_SHIFT,
        SCC_FR_UART7,
        SCC_FR_UART8,
        SCC_FR_UART9
    } scc_frame_t;

    // shift clock source codes in field order
    typedef enum logic [1:0] {
        SCC_CK_TIMER,
        SCC_CK_BAUD,
        SCC_CK_INT,
        SCC_CK_NONE
    } scc_clk_src_t;

    // register state of one channel
    typedef struct packed {
        logic rx9;
        logic even;
        logic pen;
        logic ovr;
        logic per;
        logic fer;
        logic edge_sel;
        logic pin_src;
        logic tx9;
        logic cts_en;
        logic rx_en;
        logic wake_en;
        scc_frame_t frame;
        scc_clk_src_t clk_src;
        logic [1:0] presc;
        logic [3:0] div;
    } scc_chan_regs_t;

    // receive result reported by a shifter, pulses for one cycle
    typedef struct packed {
        logic done;
        logic [8:0] data;
        logic ovr;
        logic per;
        logic fer;
    } scc_rx_event_t;

    // configuration handed to a shifter
    typedef struct packed {
        scc_frame_t frame;
        logic even;
        logic pen;
        logic tx9;
        logic cts_en;
        logic rx_en;
        logic wake_en;
        logic pin_clk;
        logic shift_tick;
    } scc_chan_cfg_t;

    // whole state of the top module
    typedef struct packed {
        scc_chan_regs_t [1:0] ch;
        logic [7:0] rx_buf1;
        logic [7:0] tx_buf1;
        logic tx_load1;
        logic [1:0] open_drain_ctrl;
        logic [7:0] int_stat;
        logic [7:0] int_mask;
        logic ack;
        logic [7:0] rdata;
        logic [1:0] sclk_meta;
        logic [1:0] sclk_sync;
        logic [1:0] sclk_prev;
        logic [1:0] sclk_tgl;
        logic [1:0] shift_tick;
        logic [1:0] txd_out;
        logic [1:0] txd_oe_n;
    } scc_top_state_t;

endpackage : scc_pkg

//--- hdl/scc_baud_gen.sv
`timescale 1ns/10ps
`include "scc_cfg.svh"

module scc_baud_gen import scc_pkg::*; #(
    parameter int DIV_W = 4
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_in,
    // setup
    input wire logic [1:0] presc_in,
    input wire logic [DIV_W-1:0] div_in,
    // one-cycle baud tick
    output logic tick_out
);

    // the divisor counter must hold the documented 0..F range at least
    generate
        if (DIV_W < 4 || DIV_W > 8) begin : g_bad_width
            $error("scc_baud_gen: DIV_W must be 4 to 8");
        end
    endgenerate

    typedef struct packed {
        logic [7:0] pre;
        logic [DIV_W-1:0] cnt;
        logic tick;
    } scc_baud_state_t;

    scc_baud_state_t st_ff;
    scc_baud_state_t nxt_st;

    // tap mask of the free running prescaler
    function automatic logic [7:0] pre_mask(input logic [1:0] sel);
        logic [7:0] m;
        m = `SCC_PRE_MASK_4;
        case (sel)
            2'h0: m = `SCC_PRE_MASK_4;
            2'h1: m = `SCC_PRE_MASK_16;
            2'h2: m = `SCC_PRE_MASK_64;
            default: m = `SCC_PRE_MASK_256;
        endcase
        return m;
    endfunction : pre_mask

    // prescaler then divisor; a divisor of zero divides by the full range
    always_comb begin
        nxt_st = st_ff;
        nxt_st.pre = st_ff.pre + 8'h01;
        nxt_st.tick = 1'b0;
        if ((st_ff.pre & pre_mask(presc_in)) == pre_mask(presc_in)) begin
            // >= recovers at once when software shrinks the divisor
            if (st_ff.cnt >= DIV_W'(div_in - 1'b1)) begin
                nxt_st.cnt = '0;
                nxt_st.tick = 1'b1;
            end else begin
                nxt_st.cnt = st_ff.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign tick_out = st_ff.tick;

    property p_presc_tap;
        @(posedge ref_clk_in) disable iff (reset_in)
        tick_out |-> (($past(st_ff.pre) & pre_mask($past(presc_in)))
            == pre_mask($past(presc_in)));
    endproperty
    a_presc_tap: assert property (p_presc_tap)
        else $error("baud tick not on prescaler tap");

endmodule : scc_baud_gen

//--- hdl/scc_serial_cfg.sv
`timescale 1ns/10ps
`include "scc_cfg.svh"

module scc_serial_cfg import scc_pkg::*; (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_in,
    // avalon-mm register slave, byte address
    input wire logic [8:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // receive results from the two shifters
    input wire scc_rx_event_t [1:0] rx_event_in,
    // timer zero output trigger, same clock
    input wire logic timer_zero_output_in,
    // serial data from the two transmit shifters
    input wire logic [1:0] txd_in,
    // channel one transmit buffer
    output logic [7:0] tx_data_out,
    output logic tx_load_out,
    // configuration of both channels
    output scc_chan_cfg_t [1:0] chan_cfg_out,
    // serial clock pins
    input wire logic [1:0] serial_clock_pin_in,
    output logic [1:0] serial_clock_pin_out,
    output logic [1:0] serial_clock_pin_oe_n_out,
    // serial data pins
    output logic [1:0] txd_pin_out,
    output logic [1:0] txd_pin_oe_n_out,
    // interrupt
    output logic irq_out
);

    localparam logic [6:0] CTRL_IDX [2] = '{`SCC_IDX_S0_CTRL,
        `SCC_IDX_S1_CTRL};
    localparam logic [6:0] MODE_IDX [2] = '{`SCC_IDX_S0_MODE,
        `SCC_IDX_S1_MODE};
    localparam logic [6:0] BAUD_IDX [2] = '{`SCC_IDX_S0_BAUD,
        `SCC_IDX_S1_BAUD};

    scc_top_state_t st_ff;
    scc_top_state_t nxt_st;

    logic [6:0] idx;
    logic [7:0] wd;
    logic req;
    logic acc;
    logic wr_acc;
    logic rd_acc;
    logic [1:0] baud_tick;

    // bus decode; only the low byte lane carries register data
    assign idx = avs_address_in[8:2];
    assign wd = avs_writedata_in[7:0];
    assign req = avs_read_in | avs_write_in;
    assign acc = req & st_ff.ack;
    assign wr_acc = acc & avs_write_in & avs_byteenable_in[0];
    assign rd_acc = acc & avs_read_in;
    assign avs_waitrequest_out = req & ~st_ff.ack;

    // one baud generator per channel
    genvar gc;
    generate
        for (gc = 0; gc < 2; gc++) begin : g_baud
            scc_baud_gen #(
                .DIV_W(4)
            ) u_baud (
                .ref_clk_in(ref_clk_in),
                .reset_in(reset_in),
                .presc_in(st_ff.ch[gc].presc),
                .div_in(st_ff.ch[gc].div),
                .tick_out(baud_tick[gc])
            );
        end
    endgenerate

    // control byte: ninth bit, parity, error flags, clock pin setup
    function automatic logic [7:0] ctrl_byte(input scc_chan_regs_t r);
        logic [7:0] v;
        v = `SCC_RST_REG;
        v[`SCC_B_RX9] = r.rx9;
        v[`SCC_B_EVEN] = r.even;
        v[`SCC_B_PEN] = r.pen;
        v[`SCC_B_OVR] = r.ovr;
        v[`SCC_B_PER] = r.per;
        v[`SCC_B_FER] = r.fer;
        v[`SCC_B_EDGE] = r.edge_sel;
        v[`SCC_B_PINSRC] = r.pin_src;
        return v;
    endfunction : ctrl_byte

    // mode byte: ninth transmit bit, enables, frame and clock source
    function automatic logic [7:0] mode_byte(input scc_chan_regs_t r);
        logic [7:0] v;
        v = `SCC_RST_REG;
        v[`SCC_B_TX9] = r.tx9;
        v[`SCC_B_CTS] = r.cts_en;
        v[`SCC_B_RXEN] = r.rx_en;
        v[`SCC_B_WAKE] = r.wake_en;
        v[`SCC_F_FRAME] = r.frame;
        v[`SCC_F_CLKSRC] = r.clk_src;
        return v;
    endfunction : mode_byte

    // baud byte; bits above the prescaler field read as zero
    function automatic logic [7:0] baud_byte(input scc_chan_regs_t r);
        logic [7:0] v;
        v = `SCC_RST_REG;
        v[`SCC_F_PRESC] = r.presc;
        v[`SCC_F_DIV] = r.div;
        return v;
    endfunction : baud_byte

    // read mux; unmapped indices answer zero
    function automatic logic [7:0] rd_reg(input logic [6:0] i,
        input scc_top_state_t s);
        logic [7:0] v;
        v = `SCC_RST_REG;
        case (i)
            `SCC_IDX_S0_CTRL: v = ctrl_byte(s.ch[0]);
            `SCC_IDX_S0_MODE: v = mode_byte(s.ch[0]);
            `SCC_IDX_S0_BAUD: v = baud_byte(s.ch[0]);
            `SCC_IDX_S1_BUF: v = s.rx_buf1;
            `SCC_IDX_S1_CTRL: v = ctrl_byte(s.ch[1]);
            `SCC_IDX_S1_MODE: v = mode_byte(s.ch[1]);
            `SCC_IDX_S1_BAUD: v = baud_byte(s.ch[1]);
            `SCC_IDX_ODE: v = {6'h00, s.open_drain_ctrl};
            `SCC_IDX_INT_STAT: v = s.int_stat;
            `SCC_IDX_INT_MASK: v = s.int_mask;
            default: v = `SCC_RST_REG;
        endcase
        return v;
    endfunction : rd_reg

    // next state of registers, pins and bus answer
    always_comb begin
        logic pin_edge;
        logic src_tick;
        pin_edge = 1'b0;
        src_tick = 1'b0;
        nxt_st = st_ff;

        // bus: wait one cycle, then answer; data is captured meanwhile
        nxt_st.ack = req & ~st_ff.ack;
        if (req && !st_ff.ack) begin
            nxt_st.rdata = rd_reg(idx, st_ff);
        end

        // channel one buffer and shared registers
        nxt_st.tx_load1 = 1'b0;
        if (wr_acc && idx == `SCC_IDX_S1_BUF) begin
            nxt_st.tx_buf1 = wd;
            nxt_st.tx_load1 = 1'b1;
        end
        if (wr_acc && idx == `SCC_IDX_ODE) begin
            nxt_st.open_drain_ctrl = wd[1:0];
        end
        if (wr_acc && idx == `SCC_IDX_INT_MASK) begin
            nxt_st.int_mask = wd;
        end
        // write one to clear; the event sets below come later and win
        if (wr_acc && idx == `SCC_IDX_INT_STAT) begin
            nxt_st.int_stat = st_ff.int_stat & ~wd;
        end
        if (rx_event_in[1].done) begin
            nxt_st.rx_buf1 = rx_event_in[1].data[7:0];
        end

        for (int c = 0; c < 2; c++) begin
            // read of control clears the error flags
            if (rd_acc && idx == CTRL_IDX[c]) begin
                nxt_st.ch[c].ovr = 1'b0;
                nxt_st.ch[c].per = 1'b0;
                nxt_st.ch[c].fer = 1'b0;
            end
            if (wr_acc && idx == CTRL_IDX[c]) begin
                nxt_st.ch[c].even = wd[`SCC_B_EVEN];
                nxt_st.ch[c].pen = wd[`SCC_B_PEN];
                nxt_st.ch[c].edge_sel = wd[`SCC_B_EDGE];
                nxt_st.ch[c].pin_src = wd[`SCC_B_PINSRC];
            end
            if (wr_acc && idx == MODE_IDX[c]) begin
                nxt_st.ch[c].tx9 = wd[`SCC_B_TX9];
                // channel one has no flow control, the bit stays zero
                nxt_st.ch[c].cts_en = (c == 0) ? wd[`SCC_B_CTS] : 1'b0;
                nxt_st.ch[c].rx_en = wd[`SCC_B_RXEN];
                nxt_st.ch[c].wake_en = wd[`SCC_B_WAKE];
                nxt_st.ch[c].frame = scc_frame_t'(wd[`SCC_F_FRAME]);
                nxt_st.ch[c].clk_src = scc_clk_src_t'(wd[`SCC_F_CLKSRC]);
            end
            if (wr_acc && idx == BAUD_IDX[c]) begin
                nxt_st.ch[c].presc = wd[`SCC_F_PRESC];
                nxt_st.ch[c].div = wd[`SCC_F_DIV];
            end

            // receive events; a set in the clearing cycle wins
            if (rx_event_in[c].done) begin
                nxt_st.ch[c].rx9 = rx_event_in[c].data[8];
                nxt_st.int_stat[`SCC_IRQ_PER_CH * c + `SCC_IRQ_RX] = 1'b1;
            end
            if (rx_event_in[c].ovr) begin
                nxt_st.ch[c].ovr = 1'b1;
                nxt_st.int_stat[`SCC_IRQ_PER_CH * c + `SCC_IRQ_OVR] = 1'b1;
            end
            if (rx_event_in[c].per) begin
                nxt_st.ch[c].per = 1'b1;
                nxt_st.int_stat[`SCC_IRQ_PER_CH * c + `SCC_IRQ_PER] = 1'b1;
            end
            if (rx_event_in[c].fer) begin
                nxt_st.ch[c].fer = 1'b1;
                nxt_st.int_stat[`SCC_IRQ_PER_CH * c + `SCC_IRQ_FER] = 1'b1;
            end

            // clock pin synchroniser; edges are found between the second and third stages
            nxt_st.sclk_meta[c] = serial_clock_pin_in[c];
            nxt_st.sclk_sync[c] = st_ff.sclk_meta[c];
            nxt_st.sclk_prev[c] = st_ff.sclk_sync[c];
            if (st_ff.ch[c].edge_sel) begin
                pin_edge = st_ff.sclk_prev[c] & ~st_ff.sclk_sync[c];
            end else begin
                pin_edge = ~st_ff.sclk_prev[c] & st_ff.sclk_sync[c];
            end

            // internal source runs every cycle; code 11 gives no clock
            case (st_ff.ch[c].clk_src)
                SCC_CK_TIMER: src_tick = timer_zero_output_in;
                SCC_CK_BAUD: src_tick = baud_tick[c];
                SCC_CK_INT: src_tick = 1'b1;
                default: src_tick = 1'b0;
            endcase

            // pin-driven clock overrides the internal sources
            nxt_st.shift_tick[c] = st_ff.ch[c].pin_src ? pin_edge
                : src_tick;
            if (!st_ff.ch[c].pin_src && src_tick) begin
                nxt_st.sclk_tgl[c] = ~st_ff.sclk_tgl[c];
            end

            // open drain drives low only and releases for a one
            if (st_ff.open_drain_ctrl[c]) begin
                nxt_st.txd_out[c] = 1'b0;
                nxt_st.txd_oe_n[c] = txd_in[c];
            end else begin
                nxt_st.txd_out[c] = txd_in[c];
                nxt_st.txd_oe_n[c] = 1'b0;
            end
        end
    end

    // every field resets to zero; buffers need no other value
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // outputs all come from the state register
    assign avs_readdata_out = {24'h000000, st_ff.rdata};
    assign tx_data_out = st_ff.tx_buf1;
    assign tx_load_out = st_ff.tx_load1;
    assign serial_clock_pin_out = st_ff.sclk_tgl;
    assign serial_clock_pin_oe_n_out = {st_ff.ch[1].pin_src,
        st_ff.ch[0].pin_src};
    assign txd_pin_out = st_ff.txd_out;
    assign txd_pin_oe_n_out = st_ff.txd_oe_n;
    assign irq_out = |(st_ff.int_stat & st_ff.int_mask);

    // per-channel configuration for the shifters
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            chan_cfg_out[c].frame = st_ff.ch[c].frame;
            chan_cfg_out[c].even = st_ff.ch[c].even;
            chan_cfg_out[c].pen = st_ff.ch[c].pen;
            chan_cfg_out[c].tx9 = st_ff.ch[c].tx9;
            chan_cfg_out[c].cts_en = st_ff.ch[c].cts_en;
            chan_cfg_out[c].rx_en = st_ff.ch[c].rx_en;
            chan_cfg_out[c].wake_en = st_ff.ch[c].wake_en;
            chan_cfg_out[c].pin_clk = st_ff.ch[c].pin_src;
            chan_cfg_out[c].shift_tick = st_ff.shift_tick[c];
        end
    end

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (reset_in);

    property p_frame_write;
        wr_acc && idx == `SCC_IDX_S0_MODE |=>
            chan_cfg_out[0].frame == scc_frame_t'($past(wd[3:2]));
    endproperty
    a_frame_write: assert property (p_frame_write)
        else $error("frame type not taken from mode write");

    property p_baud_src;
        st_ff.ch[0].clk_src == SCC_CK_BAUD && !st_ff.ch[0].pin_src
            && baud_tick[0] |=> chan_cfg_out[0].shift_tick;
    endproperty
    a_baud_src: assert property (p_baud_src)
        else $error("baud tick did not reach shift clock");

    property p_ctrl_read;
        rd_acc && idx == `SCC_IDX_S1_CTRL |->
            avs_readdata_out[7:5] == $past({st_ff.ch[1].rx9,
            st_ff.ch[1].even, st_ff.ch[1].pen});
    endproperty
    a_ctrl_read: assert property (p_ctrl_read)
        else $error("control read shows wrong ninth bit or parity");

    property p_err_clear;
        rd_acc && idx == `SCC_IDX_S0_CTRL && !rx_event_in[0].ovr
            && !rx_event_in[0].fer |=> !st_ff.ch[0].ovr && !st_ff.ch[0].fer;
    endproperty
    a_err_clear: assert property (p_err_clear)
        else $error("error flags not cleared by control read");

    property p_err_set;
        rx_event_in[1].per |=> st_ff.ch[1].per ##1 1'b1;
    endproperty
    a_err_set: assert property (p_err_set)
        else $error("parity error flag not set");

    property p_mode_write;
        wr_acc && idx == `SCC_IDX_S0_MODE |=>
            {chan_cfg_out[0].tx9, chan_cfg_out[0].cts_en,
            chan_cfg_out[0].rx_en, chan_cfg_out[0].wake_en}
            == $past(wd[7:4]);
    endproperty
    a_mode_write: assert property (p_mode_write)
        else $error("mode enables not taken from write");

    property p_pin_clock;
        st_ff.ch[0].pin_src && !st_ff.ch[0].edge_sel && !st_ff.sclk_prev[0]
            && st_ff.sclk_sync[0] |=> chan_cfg_out[0].shift_tick
            && serial_clock_pin_oe_n_out[0];
    endproperty
    a_pin_clock: assert property (p_pin_clock)
        else $error("pin edge did not give a shift clock");

    property p_buf_write;
        wr_acc && idx == `SCC_IDX_S1_BUF |=> tx_load_out
            && tx_data_out == $past(wd) ##1 !tx_load_out;
    endproperty
    a_buf_write: assert property (p_buf_write)
        else $error("transmit buffer write not loaded");

    property p_open_drain;
        st_ff.open_drain_ctrl[1] |=> !txd_pin_out[1];
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("open-drain output drove high");

endmodule : scc_serial_cfg

//--- sim/scc_far_dev.sv
`timescale 1ns/10ps

module scc_far_dev (
    // clock
    input wire logic ref_clk_in,
    // serial data pins of the block
    input wire logic [1:0] txd_pin_in,
    input wire logic [1:0] txd_oe_n_in,
    // lines seen by the block
    output logic [1:0] clk_line_out,
    output logic [1:0] txd_line_out
);
    // pull-up: a released data line reads high
    assign txd_line_out = txd_pin_in | txd_oe_n_in;

    initial clk_line_out = 2'b00;

    // external clock stands low between bursts
    task automatic pulses(input int ch, input int n);
        for (int i = 0; i < n; i++) begin
            repeat (4) @(posedge ref_clk_in);
            clk_line_out[ch] <= 1'b1;
            repeat (4) @(posedge ref_clk_in);
            clk_line_out[ch] <= 1'b0;
        end
    endtask : pulses
endmodule : scc_far_dev

//--- sim/testbench.sv
`timescale 1ns/10ps

`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_errors++; \
    $display("[FAIL] %0t mismatch %h %h", $time, (a), (b)); end end

module testbench;
    import scc_pkg::*;
    logic ref_clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic [8:0] addr = '0;
    logic rd_r = 1'b0;
    logic wr_r = 1'b0;
    logic [31:0] wdata = '0;
    logic [31:0] rdata;
    logic waitreq;
    scc_rx_event_t [1:0] rx_ev = '0;
    logic tmr = 1'b0;
    logic [1:0] txd = 2'b00;
    logic [7:0] tx_data;
    logic tx_load;
    scc_chan_cfg_t [1:0] cfg;
    logic [1:0] sck_in, sck_out, sck_oe_n, txd_pin, txd_oe_n, line;
    logic irq;
    int n_errors = 0, compares = 0, cyc = 0, n_load = 0, n_tick = 0, n;

    always #50 ref_clk_in = ~ref_clk_in;

    // event counters and hang guard
    always @(posedge ref_clk_in) begin
        cyc++;
        if (cfg[0].shift_tick === 1'b1) n_tick++;
        if (tx_load === 1'b1) n_load++;
        if (cyc == 30000) begin
            n_errors++;
            report_and_stop();
        end
    end

    scc_serial_cfg scc_serial_cfg_i (.ref_clk_in(ref_clk_in),
        .reset_in(reset_in), .avs_address_in(addr), .avs_read_in(rd_r),
        .avs_write_in(wr_r), .avs_writedata_in(wdata),
        .avs_byteenable_in(4'hF), .avs_readdata_out(rdata),
        .avs_waitrequest_out(waitreq), .rx_event_in(rx_ev),
        .timer_zero_output_in(tmr), .txd_in(txd), .tx_data_out(tx_data),
        .tx_load_out(tx_load), .chan_cfg_out(cfg),
        .serial_clock_pin_in(sck_in), .serial_clock_pin_out(sck_out),
        .serial_clock_pin_oe_n_out(sck_oe_n), .txd_pin_out(txd_pin),
        .txd_pin_oe_n_out(txd_oe_n), .irq_out(irq));

    scc_far_dev scc_far_dev_i (.ref_clk_in(ref_clk_in),
        .txd_pin_in(txd_pin), .txd_oe_n_in(txd_oe_n),
        .clk_line_out(sck_in), .txd_line_out(line));

    // request held until waitrequest is seen low
    task automatic bus(input logic w, input logic [6:0] idx,
        input logic [7:0] d, output logic [7:0] q);
        @(posedge ref_clk_in);
        wr_r <= w;
        rd_r <= !w;
        addr <= {idx, 2'b00};
        wdata <= {24'h000000, d};
        @(posedge ref_clk_in);
        while (waitreq !== 1'b0) @(posedge ref_clk_in);
        q = rdata[7:0];
        wr_r <= 1'b0;
        rd_r <= 1'b0;
    endtask : bus

    task automatic wr(input logic [6:0] idx, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, idx, d, q);
    endtask : wr

    task automatic rdchk(input logic [6:0] idx, input logic [7:0] e);
        logic [7:0] q;
        bus(1'b0, idx, 8'h00, q);
        `CHK(q, e)
        `CHK(rdata[31:8], 24'h000000)
    endtask : rdchk

    // one-cycle receive result from a shifter
    task automatic ev(input int ch, input scc_rx_event_t e);
        @(posedge ref_clk_in);
        rx_ev[ch] <= e;
        @(posedge ref_clk_in);
        rx_ev[ch] <= '0;
    endtask : ev

    task automatic t_reset();
        for (int i = 'h50; i <= 'h5A; i++) begin
            rdchk(7'(i), 8'h00);
        end
        `CHK(irq, 1'b0)
    endtask : t_reset

    // read-only and fixed bits keep their value under an all-ones write
    task automatic t_regs();
        logic [6:0] ri [7] = '{7'h51, 7'h52, 7'h53, 7'h55, 7'h56, 7'h57,
            7'h58};
        logic [7:0] rm [7] = '{8'h63, 8'hFF, 8'h3F, 8'h63, 8'hBF, 8'h3F,
            8'h03};
        for (int i = 0; i < 7; i++) wr(ri[i], 8'hFF);
        for (int i = 0; i < 7; i++) rdchk(ri[i], rm[i]);
        `CHK(cfg[0][9:2], 8'hFF)
        `CHK(cfg[1][9:2], 8'hFB)
        for (int i = 0; i < 7; i++) wr(ri[i], 8'h00);
    endtask : t_regs

    task automatic t_frame();
        for (int f = 0; f < 4; f++) begin
            wr(7'h52, {4'h0, 2'(f), 2'b10});
            @(negedge ref_clk_in);
            `CHK(cfg[0].frame, scc_frame_t'(f))
        end
    endtask : t_frame

    task automatic pulse_timer(input int k);
        repeat (k) begin
            @(posedge ref_clk_in);
            tmr <= 1'b1;
            @(posedge ref_clk_in);
            tmr <= 1'b0;
        end
        repeat (4) @(posedge ref_clk_in);
    endtask : pulse_timer

    task automatic t_tick();
        int per;
        logic b;
        wr(7'h52, 8'h02);
        repeat (4) @(negedge ref_clk_in);
        n = n_tick;
        repeat (40) @(negedge ref_clk_in);
        `CHK(n_tick - n, 40)
        wr(7'h52, 8'h00);
        // let the last internal tick drain before counting
        repeat (2) @(negedge ref_clk_in);
        n = n_tick;
        b = sck_out[0];
        pulse_timer(3);
        `CHK(n_tick - n, 3)
        `CHK(sck_out[0], ~b)
        wr(7'h52, 8'h03);
        n = n_tick;
        pulse_timer(2);
        `CHK(n_tick - n, 0)
        wr(7'h52, 8'h01);
        for (int p = 0; p < 4; p++) begin
            per = 2 << (2 * p + 2);
            wr(7'h53, {2'b00, 2'(p), 4'h2});
            repeat (per) @(negedge ref_clk_in);
            n = n_tick;
            repeat (2 * per) @(negedge ref_clk_in);
            `CHK(n_tick - n, 2)
        end
    endtask : t_tick

    task automatic t_pin();
        for (int e = 0; e < 2; e++) begin
            wr(7'h51, {6'h00, 1'(e), 1'b1});
            repeat (4) @(posedge ref_clk_in);
            `CHK(sck_oe_n[0], 1'b1)
            n = n_tick;
            scc_far_dev_i.pulses(0, 3);
            repeat (8) @(posedge ref_clk_in);
            `CHK(n_tick - n, 3)
        end
        wr(7'h51, 8'h00);
        @(negedge ref_clk_in);
        `CHK(sck_oe_n[0], 1'b0)
    endtask : t_pin

    task automatic t_err();
        wr(7'h5A, 8'hFF);
        ev(0, 13'h0007);
        @(negedge ref_clk_in);
        `CHK(irq, 1'b1)
        rdchk(7'h51, 8'h1C);
        rdchk(7'h51, 8'h00);
        rdchk(7'h59, 8'h0E);
        wr(7'h59, 8'h0E);
        rdchk(7'h59, 8'h00);
        `CHK(irq, 1'b0)
        wr(7'h5A, 8'h00);
        ev(1, 13'h0004);
        rdchk(7'h59, 8'h20);
        `CHK(irq, 1'b0)
        rdchk(7'h55, 8'h10);
        wr(7'h59, 8'hFF);
    endtask : t_err

    task automatic t_data();
        ev(0, {1'b1, 9'h1A5, 3'b000});
        ev(1, {1'b1, 9'h15A, 3'b000});
        rdchk(7'h51, 8'h80);
        rdchk(7'h54, 8'h5A);
        rdchk(7'h55, 8'h80);
        rdchk(7'h59, 8'h11);
        wr(7'h59, 8'h11);
        n = n_load;
        wr(7'h54, 8'hC3);
        repeat (2) @(posedge ref_clk_in);
        `CHK(n_load - n, 1)
        `CHK(tx_data, 8'hC3)
    endtask : t_data

    // released high level comes from the far side pull-up
    task automatic t_od();
        @(posedge ref_clk_in);
        txd <= 2'b01;
        wr(7'h58, 8'h01);
        repeat (2) @(negedge ref_clk_in);
        `CHK(txd_oe_n[0], 1'b1)
        `CHK(line[0], 1'b1)
        @(posedge ref_clk_in);
        txd <= 2'b00;
        repeat (2) @(negedge ref_clk_in);
        `CHK({txd_oe_n[0], line[0]}, 2'b00)
        wr(7'h58, 8'h00);
        @(posedge ref_clk_in);
        txd <= 2'b11;
        repeat (2) @(negedge ref_clk_in);
        `CHK({txd_oe_n, line}, 4'h3)
    endtask : t_od

    task automatic report_and_stop();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : report_and_stop

    // reset, then scenarios in turn
    initial begin
        repeat (16) @(posedge ref_clk_in);
        reset_in <= 1'b0;
        @(posedge ref_clk_in);
        t_reset();
        t_regs();
        t_frame();
        t_tick();
        t_pin();
        t_err();
        t_data();
        t_od();
        report_and_stop();
    end
endmodule : testbench
